// ===== common/srd_defines.svh
`ifndef SRD_DEFINES_SVH
`define SRD_DEFINES_SVH

// Reset hold after power-good rises, in ns, and derived cycles at 5 ns
`define SRD_RST_HOLD_NS      32'd100
`define SRD_CLK_NS           32'd5
`define SRD_RST_HOLD_CYC     8'((`SRD_RST_HOLD_NS + `SRD_CLK_NS - 32'd1) / `SRD_CLK_NS)
// Core-init pulse width in cycles
`define SRD_INIT_PULSE_CYC   8'h08
// Cycles the strap settles before it is sampled
`define SRD_STRAP_SETTLE_CYC 8'h04
// Reset values
`define SRD_CNT_RST          8'h00
`define SRD_CBE_RST          4'h0

`endif

// ===== common/srd_pkg.sv
package srd_pkg;

  typedef enum logic [1:0] {
    SRD_ST_RESET,
    SRD_ST_STRAP,
    SRD_ST_HOLD,
    SRD_ST_RUN
  } srd_state_e;

  // PCI command/byte-enable pin drive value and enable
  typedef struct packed {
    logic [3:0] o;
    logic [3:0] oe_n;
  } srd_cbe_s;

  // Reset outputs toward CPU and buses
  typedef struct packed {
    logic cpu_reset;
    logic cpu_init;
    logic isa_reset;
    logic dev_reset;
  } srd_rst_s;

endpackage

// ===== hw/srd_sync.sv
`timescale 1ns/1ps
`include "srd_defines.svh"

module srd_sync
  import srd_pkg::*;
(
  input  wire logic clock, // Clock
  input  wire logic srst,  // Synchronous reset
  input  wire logic d,     // Asynchronous level
  output logic      q      // Synchronised level
);

  typedef struct packed {
    logic s1;
    logic s2;
  } srd_sync_s;

  srd_sync_s st_q;
  srd_sync_s st_d;

  // Two flops in series
  always_comb
  begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clock)
  begin
    if (srst)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q = st_q.s2;

endmodule // srd_sync

// ===== hw/srd_reset_dist.sv
`timescale 1ns/1ps
`include "srd_defines.svh"

// How it works
// - Power-good low reloads the hold count and clears core init; strap mode kept
// - Drive CPU reset for CPU and ISA
// - Normal mode: PCI reset pin is output
// - Strap low: PCI reset input resets device, ISA
// - Pin undriven with pull-up until strap sampled
// - After sampling, drive if strap high
// - Core-init output resets only CPU core
// - Core-init returns CPU to real mode
// - Drive C/BE as master, sample as target
module srd_reset_dist
  import srd_pkg::*;
(
  input  wire logic       clock,             // PCI clock
  input  wire logic       srst,              // Synchronous reset
  input  wire logic       power_good_in,     // Power good pin
  input  wire logic       standalone_strap,  // Stand-alone strap pin
  input  wire logic       pci_bus_reset_i,   // Reset pin level, active low
  output logic            pci_bus_reset_o,   // Reset pin drive value
  output logic            pci_bus_reset_oe_n,// Reset pin enable, low drives
  output logic            pullup_en,         // Internal pull-up on pin
  output logic            cpu_reset_out,     // CPU and ISA reset
  output logic            isa_reset_out,     // ISA bus reset
  output logic            cpu_init_out,      // CPU core init pulse
  output logic            dev_reset_out,     // Internal device reset
  output logic            standalone_mode,   // Strap sampled low
  input  wire logic       core_init_req,     // Request real-mode return
  input  wire logic       bus_master,        // Device owns the bus
  input  wire logic [3:0] cbe_out,           // C/BE value when master
  input  wire logic [3:0] cbe_i,             // C/BE pin levels
  output srd_cbe_s        cbe_pin,           // C/BE drive and enable
  output logic [3:0]      cbe_sampled,       // C/BE sampled as target
  input  wire logic       frame_n_i,         // Frame pin level
  output logic            frame_active       // Transaction in progress
);

  typedef struct packed {
    srd_state_e state;
    logic [7:0] cnt;
    logic       standalone;
    logic       drive_pin;
    logic [7:0] init_cnt;
    logic       init_req_q;
    logic [3:0] cbe_smp;
    logic       frame_s1;
    logic       frame_s2;
    logic       pin_s1;
    logic       pin_s2;
    logic [3:0] cbe_o;
    logic       cbe_en;
  } srd_state_s;

  srd_state_s st_q;
  srd_state_s st_d;
  logic       pg_sync;
  logic       strap_sync;
  logic       ext_reset;

  // Counter step helper
  function automatic logic [7:0] srd_dec(input logic [7:0] v);
    srd_dec = (v == 8'h00) ? 8'h00 : v - 8'h01;
  endfunction

  // Power-good and strap into the clock domain
  srd_sync u_pg_sync (
    .clock (clock),
    .srst  (srst),
    .d     (power_good_in),
    .q     (pg_sync)
  );

  srd_sync u_strap_sync (
    .clock (clock),
    .srst  (srst),
    .d     (standalone_strap),
    .q     (strap_sync)
  );

  // Stand-alone reset from pin, active low
  assign ext_reset = st_q.standalone && !st_q.pin_s2;

  // Next-state logic
  always_comb
  begin
    st_d          = st_q;
    st_d.pin_s1   = pci_bus_reset_i;
    st_d.pin_s2   = st_q.pin_s1;
    st_d.frame_s1 = frame_n_i;
    st_d.frame_s2 = st_q.frame_s1;
    st_d.init_req_q = core_init_req;
    st_d.init_cnt = srd_dec(st_q.init_cnt);
    // Master drives C/BE, target samples
    st_d.cbe_en  = bus_master;
    st_d.cbe_o   = cbe_out;
    st_d.cbe_smp = bus_master ? st_q.cbe_smp : cbe_i;
    case (st_q.state)
      SRD_ST_RESET:
      begin
        st_d.drive_pin = 1'b0;
        st_d.cnt       = `SRD_STRAP_SETTLE_CYC;
        st_d.state     = SRD_ST_STRAP;
      end
      SRD_ST_STRAP:
      begin
        st_d.cnt = srd_dec(st_q.cnt);
        if (st_q.cnt == 8'h00)
        begin
          st_d.standalone = !strap_sync;
          st_d.drive_pin  = strap_sync;
          st_d.cnt        = `SRD_RST_HOLD_CYC;
          st_d.state      = SRD_ST_HOLD;
        end
      end
      SRD_ST_HOLD:
      begin
        st_d.cnt = srd_dec(st_q.cnt);
        // A held stand-alone pin keeps the hold from running out
        if (ext_reset)
          st_d.cnt = `SRD_RST_HOLD_CYC;
        else if (st_q.cnt == 8'h00)
          st_d.state = SRD_ST_RUN;
      end
      SRD_ST_RUN:
      begin
        // Rising request gives one core-init pulse
        if (core_init_req && !st_q.init_req_q)
          st_d.init_cnt = `SRD_INIT_PULSE_CYC;
        if (ext_reset)
        begin
          st_d.cnt   = `SRD_RST_HOLD_CYC;
          st_d.state = SRD_ST_HOLD;
        end
      end
      default:
        st_d.state = SRD_ST_RESET;
    endcase
    // Power-good low reloads the hold and keeps the reset outputs asserted; C/BE and frame keep running; strap mode kept
    if (!pg_sync)
    begin
      st_d.cnt      = `SRD_RST_HOLD_CYC;
      st_d.init_cnt = `SRD_CNT_RST;
      if (st_q.state != SRD_ST_RESET && st_q.state != SRD_ST_STRAP)
        st_d.state = SRD_ST_HOLD;
    end
  end

  // State register
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      st_q          <= '0;
      st_q.state    <= SRD_ST_RESET;
      st_q.cnt      <= `SRD_CNT_RST;
      st_q.pin_s1   <= 1'b1;
      st_q.pin_s2   <= 1'b1;
      st_q.frame_s1 <= 1'b1;
      st_q.frame_s2 <= 1'b1;
      st_q.cbe_smp  <= `SRD_CBE_RST;
    end
    else
      st_q <= st_d;
  end

  // Reset outputs: asserted outside run state
  logic in_reset;
  assign in_reset = (st_q.state != SRD_ST_RUN) || !pg_sync;
  assign cpu_reset_out   = in_reset;
  assign isa_reset_out   = in_reset;
  assign dev_reset_out   = in_reset;
  assign cpu_init_out    = (st_q.init_cnt != 8'h00) && !in_reset;
  assign standalone_mode = st_q.standalone;

  // Reset pin: driven low while in reset in normal mode
  assign pci_bus_reset_o    = !in_reset;
  assign pci_bus_reset_oe_n = !st_q.drive_pin;
  assign pullup_en          = !st_q.drive_pin;

  // PCI sideband
  assign cbe_pin.o    = st_q.cbe_o;
  assign cbe_pin.oe_n = {4{!st_q.cbe_en}};
  assign cbe_sampled  = st_q.cbe_smp;
  assign frame_active = !st_q.frame_s2;

endmodule // srd_reset_dist

// ===== verif/srd_reset_dist_properties.sv
`timescale 1ns/1ps
module srd_reset_dist_properties
  import srd_pkg::*;
(
  input wire logic     clock,              // Clock
  input wire logic     srst,               // Reset
  input wire logic     power_good_in,      // Power good
  input wire logic     pci_bus_reset_i,    // Pin level
  input wire logic     pci_bus_reset_o,    // Pin value
  input wire logic     pci_bus_reset_oe_n, // Pin enable
  input wire logic     pullup_en,          // Pull-up
  input wire logic     cpu_reset_out,      // CPU reset
  input wire logic     isa_reset_out,      // ISA reset
  input wire logic     cpu_init_out,       // Core init
  input wire logic     standalone_mode,    // Mode
  input wire logic     core_init_req,      // Init request
  input wire logic     bus_master,         // Master
  input wire srd_cbe_s cbe_pin             // C/BE drive
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // Reset outputs against their causes
  property p_isa; isa_reset_out == cpu_reset_out; endproperty
  a_isa: assert property (p_isa) else $error("isa reset differs");
  property p_pg; !power_good_in [*5] |-> cpu_reset_out; endproperty
  a_pg: assert property (p_pg) else $error("reset not held");
  property p_pull; pullup_en == pci_bus_reset_oe_n; endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
  property p_sa; standalone_mode |-> pci_bus_reset_oe_n; endproperty
  a_sa: assert property (p_sa) else $error("pin driven");
  property p_drv;
    !pci_bus_reset_oe_n && cpu_reset_out |-> !pci_bus_reset_o;
  endproperty
  a_drv: assert property (p_drv) else $error("bus reset not low");
  property p_sain;
    (standalone_mode && !pci_bus_reset_i) [*5] |-> isa_reset_out;
  endproperty
  a_sain: assert property (p_sain) else $error("pin reset lost");
  // Core init pulse shape and cause; C/BE driven as master
  property p_ilen;
    $rose(cpu_init_out) |-> cpu_init_out [*8] ##1 !cpu_init_out;
  endproperty
  a_ilen: assert property (p_ilen) else $error("init length");
  property p_icause;
    $rose(cpu_init_out) |-> !cpu_reset_out && $past(core_init_req);
  endproperty
  a_icause: assert property (p_icause) else $error("init cause");
  property p_cbe; bus_master |=> cbe_pin.oe_n == 4'h0; endproperty
  a_cbe: assert property (p_cbe) else $error("cbe not driven");
endmodule // srd_reset_dist_properties

bind srd_reset_dist srd_reset_dist_properties u_chk (.clock(clock),
  .srst(srst), .power_good_in(power_good_in),
  .pci_bus_reset_i(pci_bus_reset_i), .pci_bus_reset_o(pci_bus_reset_o),
  .pci_bus_reset_oe_n(pci_bus_reset_oe_n), .pullup_en(pullup_en),
  .cpu_reset_out(cpu_reset_out), .isa_reset_out(isa_reset_out),
  .cpu_init_out(cpu_init_out), .standalone_mode(standalone_mode),
  .core_init_req(core_init_req), .bus_master(bus_master),
  .cbe_pin(cbe_pin));

// ===== verif/srd_far_side.sv
`timescale 1ns/1ps
module srd_far_side
(
  input  wire logic clock,    // Clock
  input  wire logic drv_o,    // Device value
  input  wire logic drv_oe_n, // Device enable
  input  wire logic pull_en,  // Device pull-up
  input  wire logic host_rst, // Far side pulls low
  output logic      pin       // Pin level
);
  logic last_q = 1'b1;
  // Resolve the reset pin from every driver
  always_comb
    if (!drv_oe_n) pin = drv_o;
    else if (host_rst) pin = 1'b0;
    else if (pull_en) pin = 1'b1;
    else pin = ~last_q;
  // Floating pin shows no stale level
  always_ff @(posedge clock) last_q <= pin;
endmodule // srd_far_side

// ===== verif/srd_reset_dist_tb.sv
`timescale 1ns/1ps
module srd_reset_dist_tb;
  import srd_pkg::*;
  logic clock, srst, power_good_in, standalone_strap, core_init_req;
  logic bus_master, frame_n_i, host_rst, pin, pin_o, pin_oe_n, pullup_en;
  logic cpu_reset_out, isa_reset_out, cpu_init_out, dev_reset_out;
  logic standalone_mode, frame_active;
  logic [3:0] cbe_out, cbe_i, cbe_sampled;
  srd_cbe_s cbe_pin;
  int mismatches, n_checks;
  // Clock source for the design
  always #2.5 clock = ~clock;
  srd_reset_dist dut (.clock(clock), .srst(srst),
    .power_good_in(power_good_in), .standalone_strap(standalone_strap),
    .pci_bus_reset_i(pin), .pci_bus_reset_o(pin_o),
    .pci_bus_reset_oe_n(pin_oe_n), .pullup_en(pullup_en),
    .cpu_reset_out(cpu_reset_out), .isa_reset_out(isa_reset_out),
    .cpu_init_out(cpu_init_out), .dev_reset_out(dev_reset_out),
    .standalone_mode(standalone_mode), .core_init_req(core_init_req),
    .bus_master(bus_master), .cbe_out(cbe_out), .cbe_i(cbe_i),
    .cbe_pin(cbe_pin), .cbe_sampled(cbe_sampled), .frame_n_i(frame_n_i),
    .frame_active(frame_active));
  srd_far_side far (.clock(clock), .drv_o(pin_o), .drv_oe_n(pin_oe_n),
    .pull_en(pullup_en), .host_rst(host_rst), .pin(pin));
  // Compare and count
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // Bounded wait for the resets to fall
  task wait_run;
    int i;
    for (i = 0; i < 80 && cpu_reset_out !== 1'b0; i++) cyc(1);
    if (i == 80)
    begin
      mismatches++;
      conclude();
    end
  endtask
  // Power loss holds resets and refuses core init
  task t_power;
    chk(8'({pin_oe_n, pullup_en, pin}), 8'h01);
    power_good_in = 0;
    // Request only once the loss has crossed the synchroniser
    cyc(3);
    core_init_req = 1;
    cyc(3);
    chk(8'({cpu_reset_out, isa_reset_out, pin, cpu_init_out}), 8'h0C);
    core_init_req = 0;
    power_good_in = 1;
    cyc(2);
    chk(8'(cpu_reset_out), 8'h01);
    wait_run();
  endtask
  // Core init pulse lasts eight cycles
  task t_init;
    int n;
    n = 0;
    core_init_req = 1;
    repeat (20)
    begin
      cyc(1);
      if (cpu_init_out === 1'b1) n++;
    end
    core_init_req = 0;
    chk(8'(n), 8'h08);
  endtask
  // Command lines driven as master, sampled as target
  task t_cbe;
    bus_master = 1;
    cbe_out = 4'hA;
    cbe_i = 4'h3;
    cyc(2);
    chk({cbe_pin.oe_n, cbe_pin.o}, 8'h0A);
    chk({cbe_pin.o, cbe_sampled}, 8'hA5);
    bus_master = 0;
    cyc(2);
    chk({cbe_pin.oe_n, cbe_sampled}, 8'hF3);
    frame_n_i = 0;
    cyc(3);
    chk(8'(frame_active), 8'h01);
    frame_n_i = 1;
    cyc(3);
    chk(8'(frame_active), 8'h00);
  endtask
  // Strap low: pin is an input that resets device and ISA
  task t_alone;
    srst = 1;
    standalone_strap = 0;
    cyc(8);
    chk(8'({pin_oe_n, pullup_en}), 8'h03);
    srst = 0;
    wait_run();
    chk(8'({standalone_mode, pin_oe_n}), 8'h03);
    host_rst = 1;
    cyc(5);
    chk(8'({dev_reset_out, isa_reset_out, cpu_reset_out}), 8'h07);
    // Held past a full hold time, the resets must still stand
    cyc(25);
    chk(8'({dev_reset_out, isa_reset_out, cpu_reset_out}), 8'h07);
    host_rst = 0;
    wait_run();
  endtask
  // Main sequence
  initial
  begin
    {clock, core_init_req, bus_master, host_rst, mismatches} = 0;
    {srst, power_good_in, standalone_strap, frame_n_i} = 4'hF;
    {cbe_out, cbe_i} = 8'h55;
    n_checks = 0;
    cyc(8);
    srst = 0;
    cyc(2);
    chk(8'({pin_oe_n, pin}), 8'h03);
    wait_run();
    t_power();
    t_init();
    t_cbe();
    t_alone();
    conclude();
  end
endmodule // srd_reset_dist_tb
